// [byte_lane_reg.sv]
`timescale 1ns/1ns
`include "usb_wrap_consts.svh"
module byte_lane_reg
    import usb_wrap_pkg::*;
#(
    parameter word_t RST_VAL = `RW_RST
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clr,
    input wire logic we,
    input wire be_t be,
    input wire word_t wdata,
    output word_t q
);

    // unselected lane keeps its old byte
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            q <= RST_VAL;
        else if (clr)
            q <= RST_VAL;
        else if (we)
        begin
            if (be[1])
                q[15:8] <= wdata[15:8];
            if (be[0])
                q[7:0] <= wdata[7:0];
        end
    end

endmodule : byte_lane_reg

// [irq_half.sv]
`timescale 1ns/1ns
module irq_half
    import usb_wrap_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clr,
    input wire word_t evt,
    input wire logic set_we,
    input wire logic clr_we,
    input wire logic mset_we,
    input wire logic mclr_we,
    input wire word_t wmask,
    output word_t raw_q,
    output word_t mask_q,
    output word_t gated
);

    word_t raw_d;
    word_t mask_d;

    // set terms are or-ed last so an event beats a clear in the same cycle
    assign raw_d = (raw_q & ~(clr_we ? wmask : '0)) | evt | (set_we ? wmask : '0);
    assign mask_d = (mask_q & ~(mclr_we ? wmask : '0)) | (mset_we ? wmask : '0);
    assign gated = raw_q & mask_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            raw_q <= '0;
            mask_q <= '0;
        end
        else if (clr)
        begin
            raw_q <= '0;
            mask_q <= '0;
        end
        else
        begin
            raw_q <= raw_d;
            mask_q <= mask_d;
        end
    end

endmodule : irq_half

// [testbench.sv]
`timescale 1ns/1ns
`include "usb_wrap_consts.svh"
module testbench;
    import usb_wrap_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic io_sel, io_we, io_rdy, irq, soft_rst_pulse, dma_abort, core_hw_rst, core_clk_en;
    logic [15:0] io_addr, io_wdata, io_rdata, status, seed, v;
    logic [1:0] lane = 2'h0;
    logic prst = 1'b0;
    logic clk_run = 1'b1;
    logic [31:0] evt = 32'h0000_0000;
    logic [16:0] exp_q [$];
    logic [16:0] ent;
    logic [15:0] rw_a [8];
    int err_total = 0;
    int compares = 0;
    int cycles = 0;

    always #5 mclk = ~mclk;

    usb_cpu_model cpu (.mclk(mclk), .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata));

    usb_wrapper_byte_access_reset DUT
    (
        .mclk(mclk), .rst(rst), .io_sel(io_sel), .io_we(io_we), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdy(io_rdy), .byte_lane_select(lane), .peripheral_reset_ctl(prst),
        .clk_run_req(clk_run), .core_status(status), .irq_evt(evt), .irq(irq),
        .soft_rst_pulse(soft_rst_pulse), .dma_abort(dma_abort), .core_hw_rst(core_hw_rst),
        .core_clk_en(core_clk_en)
    );

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic exp);
        check({15'h0000, seen}, {15'h0000, exp});
    endtask : chk1

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        exp_q.push_back(17'h0_0000);
        cpu.access(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back({1'b1, e});
        cpu.access(1'b0, a, 16'h0000);
    endtask : rd

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // every access answers once; an empty queue forces a mismatch
    always @(negedge mclk)
    begin
        if (io_rdy === 1'b1)
        begin
            ent = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1_dead;
            if (ent[16])
                check(io_rdata, ent[15:0]);
        end
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        seed = 16'h0038;
        status = lfsr(seed);
        rw_a = '{`A_EMU, `A_MODE_HI, `A_AUTOMATIC_REQUEST_CTL, `A_SRP_LO, `A_ABORT_HI, `A_EP1_LO, `A_EP3_HI, `A_EP4_HI};
        repeat (4) @(negedge mclk);
        chk1(core_hw_rst, 1'b1);
        chk1(dma_abort, 1'b1);
        rst = 1'b0;
        @(negedge mclk);
        chk1(core_hw_rst, 1'b0);
        rd(`A_REV_LO, `REV_LO_DEF);
        rd(`A_EP4_HI, `RW_RST);
        rd(`A_STAT, status);
        v = status;
        foreach (rw_a[i])
        begin
            v = lfsr(v);
            wr(rw_a[i], v);
        end
        v = status;
        foreach (rw_a[i])
        begin
            v = lfsr(v);
            rd(rw_a[i], v);
        end
        seed = lfsr(v);
        wr(`A_REV_LO, seed);
        rd(`A_REV_LO, `REV_LO_DEF);
        wr(16'h8044, seed);
        rd(16'h8044, 16'h0000);
        lane = `LANE_HIGH_CODE;
        wr(`A_EP1_LO, seed);
        rd(`A_EP1_LO, {seed[15:8], 8'h00});
        lane = `LANE_LOW_CODE;
        wr(`A_EP1_LO, ~seed);
        rd(`A_EP1_LO, {8'h00, ~seed[7:0]});
        rd(`A_STAT, {8'h00, status[7:0]});
        lane = `LANE_OFF_CODE;
        wr(`A_EP1_LO, 16'h0000);
        rd(`A_EP1_LO, 16'h0000);
        // full-word mode again before any wide register
        lane = `LANE_FULL_CODE;
        rd(`A_EP1_LO, {seed[15:8], ~seed[7:0]});
        wr(`A_CTRL, 16'h0001);
        // pulse stands only in the cycle right after the write edge
        chk1(soft_rst_pulse, 1'b1);
        chk1(dma_abort, 1'b1);
        @(negedge mclk);
        chk1(soft_rst_pulse, 1'b0);
        rd(`A_CTRL, 16'h0000);
        rd(`A_EP1_LO, 16'h0000);
        rd(`A_EMU, 16'h0000);
        wr(`A_ESET_LO, 16'h0001);
        rd(`A_EVIEW_LO, 16'h0001);
        @(negedge mclk);
        evt = 32'h0000_0003;
        @(negedge mclk);
        evt = 32'h0000_0000;
        @(negedge mclk);
        chk1(irq, 1'b1);
        rd(`A_RAW_LO, 16'h0003);
        rd(`A_GATED_LO, 16'h0001);
        rd(`A_VEC_LO, 16'h0001);
        // event and clear in one cycle: the event must survive
        evt = 32'h0000_0001;
        wr(`A_SCLR_LO, 16'h0001);
        evt = 32'h0000_0000;
        rd(`A_RAW_LO, 16'h0003);
        wr(`A_SCLR_LO, 16'h0001);
        rd(`A_RAW_LO, 16'h0002);
        repeat (3) @(negedge mclk);
        chk1(irq, 1'b1);
        wr(`A_ACK, 16'h0000);
        repeat (2) @(negedge mclk);
        chk1(irq, 1'b0);
        wr(`A_FSET_HI, 16'h8000);
        rd(`A_RAW_HI, 16'h8000);
        rd(`A_GATED_HI, 16'h0000);
        wr(`A_ESET_HI, 16'h8000);
        rd(`A_GATED_HI, 16'h8000);
        repeat (2) @(negedge mclk);
        chk1(irq, 1'b1);
        wr(`A_ECLR_HI, 16'h8000);
        rd(`A_EVIEW_HI, 16'h0000);
        rd(`A_GATED_HI, 16'h0000);
        clk_run = 1'b0;
        repeat (2) @(negedge mclk);
        chk1(core_clk_en, 1'b0);
        rst = 1'b1;
        @(negedge mclk);
        chk1(core_clk_en, 1'b1);
        rst = 1'b0;
        // core clock request raised again before the peripheral reset is used
        clk_run = 1'b1;
        repeat (2) @(negedge mclk);
        wr(`A_FSET_HI, 16'h0100);
        wr(`A_EP2_HI, seed);
        prst = 1'b1;
        repeat (2) @(negedge mclk);
        chk1(core_hw_rst, 1'b1);
        chk1(dma_abort, 1'b1);
        prst = 1'b0;
        repeat (2) @(negedge mclk);
        chk1(core_hw_rst, 1'b0);
        rd(`A_EP2_HI, `RW_RST);
        rd(`A_RAW_HI, 16'h0000);
        repeat (3) @(negedge mclk);
        check(16'(exp_q.size()), 16'h0000);
        report_and_stop();
    end
endmodule : testbench

// [usb_cpu_model.sv]
`timescale 1ns/1ns
module usb_cpu_model
(
    input wire logic mclk,
    output logic io_sel,
    output logic io_we,
    output logic [15:0] io_addr,
    output logic [15:0] io_wdata
);
    initial
    begin
        io_sel = 1'b0;
        io_we = 1'b0;
        io_addr = 16'h0000;
        io_wdata = 16'h0000;
    end

    // one-cycle request, as the register bus takes it
    task automatic access(input logic we, input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk);
        io_sel = 1'b1;
        io_we = we;
        io_addr = a;
        io_wdata = d;
        @(negedge mclk);
        io_sel = 1'b0;
        // released lines flip, so a stale copy never looks valid
        io_addr = ~a;
        io_wdata = ~d;
    endtask : access
endmodule : usb_cpu_model

// [usb_wrap_consts.svh]
`ifndef USB_WRAP_CONSTS_SVH
`define USB_WRAP_CONSTS_SVH

// ----------------------------------------
// cpu word addresses
// ----------------------------------------
`define A_REV_LO 16'h8000
`define A_REV_HI 16'h8001
`define A_CTRL 16'h8004
`define A_STAT 16'h8008
`define A_EMU 16'h800c
`define A_MODE_LO 16'h8010
`define A_MODE_HI 16'h8011
`define A_AUTOMATIC_REQUEST_CTL 16'h8014
`define A_SRP_LO 16'h8018
`define A_SRP_HI 16'h8019
`define A_ABORT_LO 16'h801c
`define A_ABORT_HI 16'h801d
`define A_RAW_LO 16'h8020
`define A_RAW_HI 16'h8021
`define A_FSET_LO 16'h8024
`define A_FSET_HI 16'h8025
`define A_SCLR_LO 16'h8028
`define A_SCLR_HI 16'h8029
`define A_EVIEW_LO 16'h802c
`define A_EVIEW_HI 16'h802d
`define A_ESET_LO 16'h8030
`define A_ESET_HI 16'h8031
`define A_ECLR_LO 16'h8034
`define A_ECLR_HI 16'h8035
`define A_GATED_LO 16'h8038
`define A_GATED_HI 16'h8039
`define A_ACK 16'h803c
`define A_VEC_LO 16'h8040
`define A_VEC_HI 16'h8041
`define A_EP1_LO 16'h8050
`define A_EP1_HI 16'h8051
`define A_EP2_LO 16'h8054
`define A_EP2_HI 16'h8055
`define A_EP3_LO 16'h8058
`define A_EP3_HI 16'h8059
`define A_EP4_LO 16'h805c
`define A_EP4_HI 16'h805d

// ----------------------------------------
// fields, lane codes, reset values
// ----------------------------------------
`define CTRL_SRST_BIT 0
`define LANE_FULL_CODE 2'h0
`define LANE_HIGH_CODE 2'h1
`define LANE_LOW_CODE 2'h2
`define LANE_OFF_CODE 2'h3
`define RW_RST 16'h0000
// arbitrary revision values
`define REV_LO_DEF 16'h0001
`define REV_HI_DEF 16'h0000

`endif

// [usb_wrap_pkg.sv]
`include "usb_wrap_consts.svh"
package usb_wrap_pkg;

    typedef enum logic [1:0]
    {
        LANE_FULL = `LANE_FULL_CODE,
        LANE_HIGH = `LANE_HIGH_CODE,
        LANE_LOW = `LANE_LOW_CODE,
        LANE_OFF = `LANE_OFF_CODE
    } lane_e;

    typedef logic [15:0] word_t;
    typedef logic [1:0] be_t;

endpackage : usb_wrap_pkg

// [usb_wrapper_byte_access_reset.sv]
`timescale 1ns/1ns
`include "usb_wrap_consts.svh"
// Operation
// - lane code zero makes a word access touch all sixteen bits.
// - lane code one limits a word access to the upper byte.
// - lane code two limits a word access to the lower byte.
// - a selected lane turns the cpu word access into one byte access.
// - two reset sources exist: hardware reset and control-register soft reset.
// - soft reset bit clears all registers and aborts running dma.
// - soft reset bit clears itself with no further write.
// - peripheral reset bit at one asserts the core reset and clears the cpu registers.
// - chip reset always also resets this controller.
// - under hardware reset every register holds its default value.
// - the controller can raise an interrupt to the cpu.
// - no system dma events; data moves by the own packet dma.
// - cpu can gate the controller clock to save idle power.
// - interrupt stays asserted until the completion ack register is written or a soft or peripheral reset clears it.
// - clear registers clear raw sources by ones; set registers set them.
// - gated status is raw and mask; mask set, cleared and read back.
module usb_wrapper_byte_access_reset
    import usb_wrap_pkg::*;
#(
    parameter word_t REV_LO_VAL = `REV_LO_DEF,
    parameter word_t REV_HI_VAL = `REV_HI_DEF
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic io_sel,
    input wire logic io_we,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    output logic io_rdy,
    input wire logic [1:0] byte_lane_select,
    input wire logic peripheral_reset_ctl,
    input wire logic clk_run_req,
    input wire logic [15:0] core_status,
    input wire logic [31:0] irq_evt,
    output logic irq,
    output logic soft_rst_pulse,
    output logic dma_abort,
    output logic core_hw_rst,
    output logic core_clk_en
);

    // ----------------------------------------
    // register index table
    // ----------------------------------------
    localparam int NRW = 17;
    localparam int I_CTRL = 0;
    localparam int I_EMU = 1;
    localparam int I_MODE_LO = 2;
    localparam word_t RW_ADDR [NRW] = '{
        `A_CTRL, `A_EMU, `A_MODE_LO, `A_MODE_HI,
        `A_AUTOMATIC_REQUEST_CTL, `A_SRP_LO, `A_SRP_HI, `A_ABORT_LO,
        `A_ABORT_HI, `A_EP1_LO, `A_EP1_HI, `A_EP2_LO,
        `A_EP2_HI, `A_EP3_LO, `A_EP3_HI, `A_EP4_LO,
        `A_EP4_HI
    };

    // ----------------------------------------
    // lane selection
    // ----------------------------------------
    lane_e lane;
    be_t be;
    word_t bmask;
    logic wr;
    logic rd;

    assign lane = lane_e'(byte_lane_select);
    // code three is undefined: no lane, write dropped, read gives zero
    assign be = (lane == LANE_FULL) ? 2'h3 :
                (lane == LANE_HIGH) ? 2'h2 :
                (lane == LANE_LOW) ? 2'h1 : 2'h0;
    assign bmask = {{8{be[1]}}, {8{be[0]}}};
    assign wr = io_sel & io_we & (|be);
    assign rd = io_sel & ~io_we;

    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    logic soft_q;
    logic soft_d;
    logic hw_q;
    logic clr;

    assign soft_d = wr & (io_addr == `A_CTRL) & be[0] & io_wdata[`CTRL_SRST_BIT];
    // synchronous wipe: soft pulse or peripheral reset level
    assign clr = soft_q | peripheral_reset_ctl;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            soft_q <= 1'b0;
        else
            soft_q <= soft_d; // one cycle only
    end

    // chip reset drives the core reset high at once
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            hw_q <= 1'b1;
        else
            hw_q <= peripheral_reset_ctl; // needs mclk running
    end

    assign soft_rst_pulse = soft_q;
    // only the own packet dma is stopped; no system dma request exists
    assign dma_abort = soft_q | hw_q;
    assign core_hw_rst = hw_q;

    // ----------------------------------------
    // clock gate request
    // ----------------------------------------
    logic clk_en_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            clk_en_q <= 1'b1;
        else
            clk_en_q <= clk_run_req;
    end

    assign core_clk_en = clk_en_q;

    // ----------------------------------------
    // plain read/write registers
    // ----------------------------------------
    word_t rw_q [NRW];

    generate
        for (genvar g = 0; g < NRW; g++)
        begin : g_rw
            byte_lane_reg #(
                .RST_VAL(`RW_RST)
            ) u_reg (
                .mclk(mclk),
                .rst(rst),
                .clr(clr),
                .we(wr && (io_addr == RW_ADDR[g])),
                .be(be),
                .wdata(io_wdata),
                .q(rw_q[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // interrupt sources and mask
    // ----------------------------------------
    word_t wmask;
    word_t raw_lo;
    word_t raw_hi;
    word_t mask_lo;
    word_t mask_hi;
    word_t gated_lo;
    word_t gated_hi;

    assign wmask = io_wdata & bmask;

    irq_half u_irq_lo (
        .mclk(mclk),
        .rst(rst),
        .clr(clr),
        .evt(irq_evt[15:0]),
        .set_we(wr && io_addr == `A_FSET_LO),
        .clr_we(wr && io_addr == `A_SCLR_LO),
        .mset_we(wr && io_addr == `A_ESET_LO),
        .mclr_we(wr && io_addr == `A_ECLR_LO),
        .wmask(wmask),
        .raw_q(raw_lo),
        .mask_q(mask_lo),
        .gated(gated_lo)
    );

    irq_half u_irq_hi (
        .mclk(mclk),
        .rst(rst),
        .clr(clr),
        .evt(irq_evt[31:16]),
        .set_we(wr && io_addr == `A_FSET_HI),
        .clr_we(wr && io_addr == `A_SCLR_HI),
        .mset_we(wr && io_addr == `A_ESET_HI),
        .mclr_we(wr && io_addr == `A_ECLR_HI),
        .wmask(wmask),
        .raw_q(raw_hi),
        .mask_q(mask_hi),
        .gated(gated_hi)
    );

    // ----------------------------------------
    // interrupt line and completion ack
    // ----------------------------------------
    logic irq_q;
    logic ack_wr;
    logic any_gated;

    assign ack_wr = wr & (io_addr == `A_ACK);
    assign any_gated = (|gated_lo) | (|gated_hi);

    // ack drops the line for one cycle so a still pending source re-edges it
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            irq_q <= 1'b0;
        else if (clr)
            irq_q <= 1'b0;
        else if (ack_wr)
            irq_q <= 1'b0;
        else if (any_gated)
            irq_q <= 1'b1;
    end

    assign irq = irq_q;

    // lowest pending gated source wins, value is index plus one, zero is none
    function automatic logic [5:0] first_set(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 31; i >= 0; i--)
        begin
            if (v[i])
                r = 6'(i + 1);
        end
        return r;
    endfunction : first_set

    logic [5:0] vec;

    assign vec = first_set({gated_hi, gated_lo});

    // ----------------------------------------
    // read path
    // ----------------------------------------
    word_t rd_word;

    always_comb
    begin
        case (io_addr)
            `A_REV_LO: rd_word = REV_LO_VAL;
            `A_REV_HI: rd_word = REV_HI_VAL;
            `A_STAT: rd_word = core_status;
            `A_RAW_LO: rd_word = raw_lo;
            `A_RAW_HI: rd_word = raw_hi;
            `A_EVIEW_LO: rd_word = mask_lo;
            `A_EVIEW_HI: rd_word = mask_hi;
            `A_GATED_LO: rd_word = gated_lo;
            `A_GATED_HI: rd_word = gated_hi;
            `A_VEC_LO: rd_word = {10'h000, vec};
            default: rd_word = '0;
        endcase
        for (int i = 0; i < NRW; i++)
        begin
            if (io_addr == RW_ADDR[i])
                rd_word = rw_q[i];
        end
    end

    word_t rdata_q;
    logic rdy_q;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdata_q <= '0;
        else if (rd)
            rdata_q <= rd_word & bmask;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdy_q <= 1'b0;
        else
            rdy_q <= io_sel;
    end

    assign io_rdata = rdata_q;
    assign io_rdy = rdy_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence s_emu_wr(lane_e l);
        wr && io_addr == `A_EMU && lane == l && !clr;
    endsequence

    sequence s_srst_wr;
        soft_d && !peripheral_reset_ctl;
    endsequence

    sequence s_srst_done;
        soft_rst_pulse && dma_abort ##1 !soft_rst_pulse && rw_q[I_CTRL] == `RW_RST && raw_lo == '0;
    endsequence

    AST_FULL_WRITE: assert property (
        s_emu_wr(LANE_FULL) |=> rw_q[I_EMU] == $past(io_wdata))
        else $error("full lane write not stored whole");

    AST_HIGH_WRITE: assert property (
        s_emu_wr(LANE_HIGH) |=> rw_q[I_EMU] == {$past(io_wdata[15:8]), $past(rw_q[I_EMU][7:0])})
        else $error("high lane write wrong");

    AST_LOW_WRITE: assert property (
        s_emu_wr(LANE_LOW) |=> rw_q[I_EMU] == {$past(rw_q[I_EMU][15:8]), $past(io_wdata[7:0])})
        else $error("low lane write wrong");

    AST_LANE_READ: assert property (
        rd && lane == LANE_HIGH |=> io_rdy && io_rdata[7:0] == 8'h00)
        else $error("unselected read byte not zero");

    AST_BYTE_READ: assert property (
        rd && lane == LANE_LOW && io_addr == `A_STAT |=> io_rdata == {8'h00, $past(core_status[7:0])})
        else $error("byte read does not carry low byte");

    AST_SOFT_RESET: assert property (
        s_srst_wr |=> s_srst_done)
        else $error("soft reset did not clear and abort");

    AST_SOFT_SELF_CLEAR: assert property (
        soft_rst_pulse && !soft_d |=> !soft_rst_pulse)
        else $error("soft reset pulse did not clear itself");

    AST_HW_RESET: assert property (
        peripheral_reset_ctl |=> core_hw_rst && rw_q[I_MODE_LO] == `RW_RST && mask_hi == '0)
        else $error("peripheral reset did not load defaults");

    AST_IRQ_HOLD: assert property (
        irq && !ack_wr && !clr |=> irq)
        else $error("interrupt dropped before ack");

    AST_IRQ_RAISE: assert property (
        raw_lo[0] && mask_lo[0] && !clr && !ack_wr |=> irq)
        else $error("gated source did not raise interrupt");

    AST_SET_WINS: assert property (
        irq_evt[0] && wr && io_addr == `A_SCLR_LO && be[0] && io_wdata[0] && !clr |=> raw_lo[0])
        else $error("event lost against clear");

    AST_CLOCK_GATE: assert property (
        $changed(clk_run_req) |=> core_clk_en == $past(clk_run_req))
        else $error("clock enable did not follow request");

endmodule : usb_wrapper_byte_access_reset
